// ==== hdl/iocm_core.sv ====
// Summary of operation
// - Port setting low nibble gives port kind.
// - Bits 4-6 select digital subentry 1-8.
// - Bit 7 picks high or low nibble.
// - Input converter selector codes 0..2.
// - Output converter selector codes 0..2.
// - Self reset after fatal delay, 100..30000 ms.
// - Analog scaling by shift mode code.
// - Analog send only after threshold change.
// - Delay service responses by set milliseconds.
// - Extra heartbeat 50 ms after bootup.
// - Rate code 1 selects 115200 baud.
// - Receive report style chosen by code.
// - Health byte zero means good setup.
// - Setup file at most 4064 bytes.
// - Key unlocks download; next key may erase.
// - Good file: program, send wait code.
// - Checksum mismatch: erase, send checksum code.
// - Unusable setup: erase, send bad code.
// - Program failure: erase, send bad code with program text.
// - Program done: send over code.
`timescale 1ns/10ps
module iocm_timer #(
  parameter int CYC = 250000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [15:0] i_ms,
  output logic o_fire
);
  logic run_q, run_d, fire_d;
  logic [15:0] ms_q, ms_d;
  logic [31:0] cyc_q, cyc_d;
  always_comb
  begin
    run_d = run_q;
    ms_d = ms_q;
    cyc_d = cyc_q;
    fire_d = 1'b0;
    if (i_go)
    begin
      run_d = 1'b1;
      ms_d = (i_ms == 16'h0000) ? 16'h0001 : i_ms;
      cyc_d = 32'h0000_0000;
    end
    else if (run_q)
    begin
      if (cyc_q == 32'(CYC - 1))
      begin
        cyc_d = 32'h0000_0000;
        ms_d = ms_q - 16'h0001;
        if (ms_q == 16'h0001)
        begin
          run_d = 1'b0;
          fire_d = 1'b1;
        end
      end
      else
        cyc_d = cyc_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_q <= 1'b0;
      ms_q <= 16'h0000;
      cyc_q <= 32'h0000_0000;
      o_fire <= 1'b0;
    end
    else
    begin
      run_q <= run_d;
      ms_q <= ms_d;
      cyc_q <= cyc_d;
      o_fire <= fire_d;
    end
  end
endmodule

module iocm_core #(
  parameter int CYC_MS = iocm_pkg::CYC_MS_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire iocm_pkg::iocm_req_s i_od,
  output iocm_pkg::iocm_rsp_s o_od,
  input wire iocm_pkg::iocm_ld_s i_ld,
  input wire logic [7:0] i_nmt_state,
  input wire logic [7:0] i_node_id,
  input wire logic [127:0] i_chip_uid,
  input wire logic i_fatal,
  input wire logic i_bootup_sent,
  input wire iocm_pkg::iocm_ain_s i_ain,
  output iocm_pkg::iocm_aout_s o_ain,
  output iocm_pkg::iocm_port_s [6:0] o_port,
  output logic [1:0] o_in_conv,
  output logic [1:0] o_out_conv,
  output logic o_uart_fast,
  output logic [1:0] o_rx_report,
  output logic o_self_reset,
  output logic o_extra_hb,
  output iocm_pkg::iocm_emcy_s o_emcy,
  output iocm_pkg::iocm_ee_s o_ee,
  input wire logic i_ee_ready,
  input wire logic i_ee_fail,
  output logic o_ee_erase
);
  import iocm_pkg::*;
  typedef enum {DL_IDLE, DL_RECV, DL_CHECK, DL_PROG} iocm_dl_e;

  ////////////////////////////////////////////////////////////////////
  // Setup entries, loaded from storage at boot; read-only on the network.
  logic [7:0] port_q [NPORT];
  logic [7:0] iconv_q, oconv_q, errc_q, shift_q, rate_q, rpt_q;
  logic [15:0] ftl_q, thr_q, rdly_q, compat_q;
  logic [7:0] health_q, health_d;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < NPORT; i++)
        port_q[i] <= 8'h00;
      iconv_q <= 8'h00;
      oconv_q <= 8'h00;
      errc_q <= 8'h00;
      shift_q <= 8'h00;
      rate_q <= 8'h00;
      rpt_q <= 8'h00;
      ftl_q <= FTL_MIN;
      thr_q <= 16'h0000;
      rdly_q <= 16'h0000;
      compat_q <= 16'h0000;
    end
    else if (i_ld.vld)
    begin
      if (i_ld.ix == IX_PORT && i_ld.sub >= 8'h01 && i_ld.sub <= 8'h07)
        port_q[3'(i_ld.sub - 8'h01)] <= i_ld.d[7:0];
      if (i_ld.ix == IX_HW)
        case (i_ld.sub)
          8'h01: iconv_q <= i_ld.d[7:0];
          8'h02: oconv_q <= i_ld.d[7:0];
          8'h03: errc_q <= i_ld.d[7:0];
          8'h04: ftl_q <= i_ld.d;
          8'h05: shift_q <= i_ld.d[7:0];
          8'h06: thr_q <= i_ld.d;
          8'h07: rdly_q <= i_ld.d;
          8'h08: compat_q <= i_ld.d;
          default: ;
        endcase
      if (i_ld.ix == IX_RMT && i_ld.sub == 8'h01)
        rate_q <= i_ld.d[7:0];
      if (i_ld.ix == IX_RMT && i_ld.sub == 8'h02)
        rpt_q <= i_ld.d[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decoded settings and health byte.
  iocm_port_s [6:0] port_d;
  always_comb
  begin
    health_d = 8'h00;
    for (int i = 0; i < NPORT; i++)
    begin
      port_d[i].kind = port_q[i][3:0];
      port_d[i].sub = {1'b0, port_q[i][6:4]} + 4'h1;
      port_d[i].hi = port_q[i][7];
      if (port_q[i][3:0] < PK_MIN || port_q[i][3:0] > PK_MAX)
        health_d[0] = 1'b1;
    end
    health_d[1] = (iconv_q > CONV_MAX) || (oconv_q > CONV_MAX);
    health_d[2] = shift_q > 8'h02;
    health_d[3] = errc_q != 8'h00;
    health_d[4] = compat_q[15:1] != 15'h0000;
    health_d[5] = ftl_q < FTL_MIN || ftl_q > FTL_MAX;
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_port <= '0;
      o_in_conv <= 2'h0;
      o_out_conv <= 2'h0;
      o_uart_fast <= 1'b0;
      o_rx_report <= 2'h0;
      health_q <= 8'h00;
    end
    else
    begin
      o_port <= port_d;
      o_in_conv <= iconv_q[1:0];
      o_out_conv <= oconv_q[1:0];
      o_uart_fast <= rate_q == RATE_FAST;
      o_rx_report <= rpt_q[1:0];
      health_q <= health_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fatal reset delay and the extra heartbeat.
  logic [15:0] ftl_ms;
  assign ftl_ms = (ftl_q < FTL_MIN) ? FTL_MIN : (ftl_q > FTL_MAX) ? FTL_MAX : ftl_q;
  iocm_timer #(.CYC(CYC_MS)) u_ftl (
    .i_clk(i_clk), .i_rst(i_rst), .i_go(i_fatal), .i_ms(ftl_ms),
    .o_fire(o_self_reset)
  );
  iocm_timer #(.CYC(CYC_MS)) u_hb (
    .i_clk(i_clk), .i_rst(i_rst), .i_go(i_bootup_sent && compat_q[0]),
    .i_ms(HB_MS), .o_fire(o_extra_hb)
  );

  ////////////////////////////////////////////////////////////////////
  // Analog scaling and change threshold.
  logic [11:0] last_q [NAIN];
  logic [11:0] diff;
  logic send;
  iocm_aout_s ain_d;
  always_comb
  begin
    diff = (i_ain.raw >= last_q[i_ain.ch]) ? i_ain.raw - last_q[i_ain.ch]
                                           : last_q[i_ain.ch] - i_ain.raw;
    send = i_ain.vld && ((thr_q == 16'h0000) ? diff != 12'h000
                                             : {4'h0, diff} >= thr_q);
    ain_d.vld = i_ain.vld;
    ain_d.tx = send;
    ain_d.ch = i_ain.ch;
    case (shift_q)
      8'h01: ain_d.val = {4'h0, i_ain.raw};
      8'h02: ain_d.val = {i_ain.raw, i_ain.raw[11:8]};
      default: ain_d.val = {i_ain.raw, 4'h0};
    endcase
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ain <= '0;
      for (int i = 0; i < NAIN; i++)
        last_q[i] <= 12'h000;
    end
    else
    begin
      o_ain <= ain_d;
      if (send)
        last_q[i_ain.ch] <= i_ain.raw;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Entry access, download engine and emergency reports.
  logic [7:0] fbuf [FILE_MAX];
  iocm_dl_e st_q, st_d;
  logic [11:0] cnt_q, cnt_d, pc_q, pc_d, base;
  logic [7:0] sum_q, sum_d;
  logic bad_q, bad_d, unl_q, unl_d, pend_q, pend_d, perr_q, perr_d;
  logic [127:0] prd_q, prd_d;
  logic take, we, erase_d, preop, dly_go, dly_fire, rsp_now;
  iocm_emcy_s emcy_d;
  iocm_ee_s ee_d;
  iocm_rsp_s rsp_d;
  assign take = i_od.vld && !pend_q;
  assign preop = i_nmt_state == NMT_PREOP;
  assign dly_go = take && rdly_q != 16'h0000;
  iocm_timer #(.CYC(CYC_MS)) u_rsp (
    .i_clk(i_clk), .i_rst(i_rst), .i_go(dly_go), .i_ms(rdly_q),
    .o_fire(dly_fire)
  );
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    sum_d = sum_q;
    bad_d = bad_q;
    unl_d = unl_q && preop;
    pend_d = pend_q;
    perr_d = perr_q;
    prd_d = prd_q;
    we = 1'b0;
    erase_d = 1'b0;
    emcy_d = '0;
    ee_d = o_ee;
    base = (st_q == DL_IDLE) ? 12'h000 : cnt_q;
    if (take)
    begin
      pend_d = 1'b1;
      perr_d = i_od.wr;
      prd_d = '0;
      case (i_od.ix)
        IX_STAT:
          case (i_od.sub)
            8'h00: prd_d[7:0] = 8'h06;
            8'h01: prd_d[7:0] = i_node_id;
            8'h02: prd_d[7:0] = i_nmt_state;
            8'h03: prd_d[7:0] = health_q;
            8'h04: prd_d[31:0] = TYPE_VER;
            8'h05: prd_d = i_chip_uid;
            8'h06: prd_d[7:0] = CHIP_KIND;
            default: perr_d = 1'b1;
          endcase
        IX_PORT:
          if (i_od.sub == 8'h00)
            prd_d[7:0] = 8'h07;
          else if (i_od.sub <= 8'h07)
            prd_d[7:0] = port_q[3'(i_od.sub - 8'h01)];
          else
            perr_d = 1'b1;
        IX_HW:
          case (i_od.sub)
            8'h00: prd_d[7:0] = 8'h08;
            8'h01: prd_d[7:0] = iconv_q;
            8'h02: prd_d[7:0] = oconv_q;
            8'h03: prd_d[7:0] = errc_q;
            8'h04: prd_d[15:0] = ftl_q;
            8'h05: prd_d[7:0] = shift_q;
            8'h06: prd_d[15:0] = thr_q;
            8'h07: prd_d[15:0] = rdly_q;
            8'h08: prd_d[15:0] = compat_q;
            default: perr_d = 1'b1;
          endcase
        IX_RMT:
          case (i_od.sub)
            8'h00: prd_d[7:0] = 8'h02;
            8'h01: prd_d[7:0] = rate_q;
            8'h02: prd_d[7:0] = rpt_q;
            default: perr_d = 1'b1;
          endcase
        IX_DL:
        begin
          perr_d = 1'b1;
          if (!preop)
            perr_d = 1'b1;
          else if (i_od.sub == 8'h00 && !i_od.wr)
          begin
            perr_d = 1'b0;
            prd_d[7:0] = 8'h02;
          end
          else if (i_od.sub == 8'h01 && i_od.wr)
          begin
            perr_d = 1'b0;
            unl_d = i_od.wd == KEY_INIT;
            if (unl_q && i_od.wd == KEY_BACK)
              erase_d = 1'b1;
          end
          else if (i_od.sub == 8'h02 && i_od.wr && unl_q && base < 12'(FILE_MAX)
                   && (st_q == DL_IDLE || st_q == DL_RECV))
          begin
            perr_d = 1'b0;
            we = 1'b1;
            cnt_d = base + 12'h001;
            sum_d = ((st_q == DL_IDLE) ? 8'h00 : sum_q) + i_od.wd[7:0];
            bad_d = (st_q == DL_IDLE) ? 1'b0 : bad_q;
            if (base < 12'(NPORT) && (i_od.wd[3:0] < PK_MIN || i_od.wd[3:0] > PK_MAX))
              bad_d = 1'b1;
            st_d = i_od.last ? DL_CHECK : DL_RECV;
          end
          else if (i_od.sub == 8'h02 && st_q == DL_RECV)
            st_d = DL_IDLE;
        end
        default: perr_d = 1'b1;
      endcase
    end
    if (rsp_now)
      pend_d = 1'b0;
    case (st_q)
      DL_CHECK:
      begin
        st_d = DL_IDLE;
        erase_d = 1'b1;
        emcy_d.vld = 1'b1;
        if (sum_q != 8'h00)
        begin
          emcy_d.code = EC_CSUM;
          emcy_d.txt = TX_CSUM;
        end
        else if (bad_q || cnt_q < 12'(NPORT))
        begin
          emcy_d.code = EC_BAD;
          emcy_d.txt = TX_BAD;
        end
        else
        begin
          erase_d = 1'b0;
          emcy_d.code = EC_WAIT;
          emcy_d.txt = TX_WAIT;
          st_d = DL_PROG;
          pc_d = 12'h000;
        end
      end
      DL_PROG:
        if (i_ee_fail)
        begin
          ee_d.vld = 1'b0;
          erase_d = 1'b1;
          emcy_d = {1'b1, EC_BAD, TX_PROG};
          st_d = DL_IDLE;
        end
        else if (!o_ee.vld || i_ee_ready)
        begin
          ee_d.vld = 1'b0;
          if (pc_q < cnt_q)
          begin
            ee_d = {1'b1, pc_q, fbuf[pc_q]};
            pc_d = pc_q + 12'h001;
          end
          else
          begin
            emcy_d = {1'b1, EC_OVER, TX_OVER};
            st_d = DL_IDLE;
          end
        end
      default: ;
    endcase
    rsp_d.ack = rsp_now;
    rsp_d.err = rsp_now && perr_q;
    rsp_d.busy = pend_d;
    rsp_d.rd = rsp_now ? prd_q : '0;
  end
  // A zero delay answers on the cycle after the request is held.
  assign rsp_now = pend_q && ((rdly_q == 16'h0000) || dly_fire);
  always_ff @(posedge i_clk)
  begin
    if (we)
      fbuf[base] <= i_od.wd[7:0];
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= DL_IDLE;
      cnt_q <= 12'h000;
      pc_q <= 12'h000;
      sum_q <= 8'h00;
      bad_q <= 1'b0;
      unl_q <= 1'b0;
      pend_q <= 1'b0;
      perr_q <= 1'b0;
      prd_q <= '0;
      o_od <= '0;
      o_emcy <= '0;
      o_ee <= '0;
      o_ee_erase <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      sum_q <= sum_d;
      bad_q <= bad_d;
      unl_q <= unl_d;
      pend_q <= pend_d;
      perr_q <= perr_d;
      prd_q <= prd_d;
      o_od <= rsp_d;
      o_emcy <= emcy_d;
      o_ee <= ee_d;
      o_ee_erase <= erase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_erase_rep(logic [15:0] c, logic [39:0] t);
    o_emcy.vld && o_emcy.code == c && o_emcy.txt == t && o_ee_erase;
  endsequence
  property p_csum;
    st_q == DL_CHECK && sum_q != 8'h00 |=> s_erase_rep(EC_CSUM, TX_CSUM);
  endproperty
  a_csum: assert property (p_csum) else $error("checksum report wrong");
  property p_bad;
    st_q == DL_CHECK && sum_q == 8'h00 && bad_q |=> s_erase_rep(EC_BAD, TX_BAD);
  endproperty
  a_bad: assert property (p_bad) else $error("bad setup report wrong");
  property p_wait;
    st_q == DL_CHECK && sum_q == 8'h00 && !bad_q && cnt_q >= 12'h007
      |=> o_emcy.code == EC_WAIT && o_emcy.txt == TX_WAIT && !o_ee_erase ##1 st_q == DL_PROG;
  endproperty
  a_wait: assert property (p_wait) else $error("wait report wrong");
  property p_pfail;
    st_q == DL_PROG && i_ee_fail |=> (s_erase_rep(EC_BAD, TX_PROG) and !o_ee.vld);
  endproperty
  a_pfail: assert property (p_pfail) else $error("program fail report wrong");
  property p_over;
    o_emcy.vld && o_emcy.txt == TX_OVER |-> o_emcy.code == EC_OVER && !o_ee_erase
      && $past(pc_q) == $past(cnt_q);
  endproperty
  a_over: assert property (p_over) else $error("over report wrong");
  property p_lock;
    take && i_od.ix == IX_DL && (!preop || (i_od.sub == 8'h02 && !unl_q))
      |=> pend_q && perr_q;
  endproperty
  a_lock: assert property (p_lock) else $error("locked access not refused");
  property p_back;
    take && preop && unl_q && i_od.ix == IX_DL && i_od.sub == 8'h01 && i_od.wr
      && i_od.wd == KEY_BACK |=> o_ee_erase && !unl_q;
  endproperty
  a_back: assert property (p_back) else $error("back key did not erase");
  property p_fast;
    take && rdly_q == 16'h0000 && $stable(rdly_q) |-> ##2 o_od.ack;
  endproperty
  a_fast: assert property (p_fast) else $error("undelayed answer late");
  property p_scale;
    i_ain.vld && shift_q == 8'h00 |=> o_ain.val == {$past(i_ain.raw), 4'h0};
  endproperty
  a_scale: assert property (p_scale) else $error("scaling wrong");
  property p_delta;
    i_ain.vld && thr_q != 16'h0000 && {4'h0, diff} < thr_q |=> !o_ain.tx;
  endproperty
  a_delta: assert property (p_delta) else $error("send below threshold");
  property p_port;
    1'b1 |=> o_port[0].sub == {1'b0, $past(port_q[0][6:4])} + 4'h1
      && o_port[0].hi == $past(port_q[0][7]);
  endproperty
  a_port: assert property (p_port) else $error("port decode wrong");
endmodule

// ==== shared/iocm_pkg.sv ====
package iocm_pkg;
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_MS_DEF = MS_NS / CLK_NS;
  localparam logic [15:0] HB_MS = 16'h0032;
  localparam logic [15:0] FTL_MIN = 16'h0064;
  localparam logic [15:0] FTL_MAX = 16'h7530;
  localparam int FILE_MAX = 4064;
  localparam int NPORT = 7;
  localparam int NAIN = 8;
  localparam logic [15:0] IX_STAT = 16'h5F00;
  localparam logic [15:0] IX_PORT = 16'h5F01;
  localparam logic [15:0] IX_HW = 16'h5F02;
  localparam logic [15:0] IX_RMT = 16'h5F03;
  localparam logic [15:0] IX_DL = 16'h5FFF;
  localparam logic [7:0] NMT_PREOP = 8'h7F;
  localparam logic [31:0] KEY_INIT = 32'h494E_4954;
  localparam logic [31:0] KEY_BACK = 32'h4241_434B;
  localparam logic [15:0] EC_WAIT = 16'hFF00;
  localparam logic [15:0] EC_CSUM = 16'hFF01;
  localparam logic [15:0] EC_BAD = 16'hFF02;
  localparam logic [15:0] EC_OVER = 16'h0000;
  localparam logic [39:0] TX_WAIT = 40'h57_4149_5420;
  localparam logic [39:0] TX_CSUM = 40'h46_4149_4C31;
  localparam logic [39:0] TX_BAD = 40'h46_4149_4C32;
  localparam logic [39:0] TX_PROG = 40'h46_4149_4C33;
  localparam logic [39:0] TX_OVER = 40'h4F_5645_5220;
  localparam logic [3:0] PK_MIN = 4'h1;
  localparam logic [3:0] PK_MAX = 4'h6;
  localparam logic [7:0] CONV_MAX = 8'h02;
  localparam logic [7:0] RATE_FAST = 8'h01;
  // Identity values below are arbitrary.
  localparam logic [31:0] TYPE_VER = 32'h0000_0100;
  localparam logic [7:0] CHIP_KIND = 8'h00;
  typedef struct packed {
    logic vld; logic wr; logic [15:0] ix; logic [7:0] sub;
    logic [31:0] wd; logic last;
  } iocm_req_s;
  typedef struct packed {
    logic ack; logic err; logic busy; logic [127:0] rd;
  } iocm_rsp_s;
  typedef struct packed {
    logic vld; logic [15:0] ix; logic [7:0] sub; logic [15:0] d;
  } iocm_ld_s;
  typedef struct packed {
    logic vld; logic [15:0] code; logic [39:0] txt;
  } iocm_emcy_s;
  typedef struct packed {
    logic [3:0] kind; logic [3:0] sub; logic hi;
  } iocm_port_s;
  typedef struct packed {
    logic vld; logic [11:0] addr; logic [7:0] d;
  } iocm_ee_s;
  typedef struct packed {
    logic vld; logic [2:0] ch; logic [11:0] raw;
  } iocm_ain_s;
  typedef struct packed {
    logic vld; logic tx; logic [2:0] ch; logic [15:0] val;
  } iocm_aout_s;
endpackage

// ==== verification/iocm_core_tb_top.sv ====
`timescale 1ns/10ps
module iocm_core_tb_top;
  import iocm_pkg::*;
  localparam int CYC = 4;
  typedef struct packed {
    logic [15:0] ix;
    logic [7:0] sb;
    logic [7:0] d;
    logic [15:0] e;
  } iocm_row_s;
  localparam iocm_row_s ROWS [0:18] = '{
    '{IX_PORT, 8'h01, 8'h01, 16'h0022}, '{IX_PORT, 8'h02, 8'h72, 16'h0050},
    '{IX_PORT, 8'h03, 8'hB3, 16'h0069}, '{IX_PORT, 8'h04, 8'hF4, 16'h0091},
    '{IX_PORT, 8'h05, 8'h85, 16'h00A3}, '{IX_PORT, 8'h06, 8'h26, 16'h00C6},
    '{IX_PORT, 8'h07, 8'h51, 16'h002C}, '{IX_HW, 8'h01, 8'h00, 16'h0000},
    '{IX_HW, 8'h01, 8'h01, 16'h0001}, '{IX_HW, 8'h01, 8'h02, 16'h0002},
    '{IX_HW, 8'h02, 8'h00, 16'h0000}, '{IX_HW, 8'h02, 8'h01, 16'h0001},
    '{IX_HW, 8'h02, 8'h02, 16'h0002}, '{IX_RMT, 8'h01, 8'h00, 16'h0000},
    '{IX_RMT, 8'h01, 8'h01, 16'h0001}, '{IX_RMT, 8'h02, 8'h00, 16'h0000},
    '{IX_RMT, 8'h02, 8'h01, 16'h0001}, '{IX_RMT, 8'h02, 8'h02, 16'h0002},
    '{IX_RMT, 8'h02, 8'h03, 16'h0003}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fatal = 1'b0;
  logic boot = 1'b0;
  logic ee_rdy = 1'b0;
  logic ee_fail = 1'b0;
  logic fast, self_rst, extra_hb, erase, er;
  logic [1:0] in_conv, out_conv, rx_rep;
  logic [7:0] nmt;
  logic [127:0] rd;
  iocm_req_s od;
  iocm_rsp_s rsp;
  iocm_ld_s ld = '0;
  iocm_ain_s ain = '0;
  iocm_aout_s aout;
  iocm_port_s [6:0] port;
  iocm_emcy_s emcy;
  iocm_ee_s ee;
  logic [55:0] em_last = '0;
  logic [16:0] av = '0;
  logic [7:0] fb [0:15];
  int err_total = 0;
  int comparisons = 0;
  int em_n = 0;
  int er_n = 0;
  int ee_n = 0;
  int an_n = 0;
  int lat;
  iocm_core #(.CYC_MS(CYC)) i_iocm_core (.i_clk(clk), .i_rst(rst), .i_od(od), .o_od(rsp),
    .i_ld(ld), .i_nmt_state(nmt), .i_node_id(8'h2A), .i_chip_uid(128'h0), .i_fatal(fatal),
    .i_bootup_sent(boot), .i_ain(ain), .o_ain(aout), .o_port(port), .o_in_conv(in_conv),
    .o_out_conv(out_conv), .o_uart_fast(fast), .o_rx_report(rx_rep), .o_self_reset(self_rst),
    .o_extra_hb(extra_hb), .o_emcy(emcy), .o_ee(ee), .i_ee_ready(ee_rdy),
    .i_ee_fail(ee_fail), .o_ee_erase(erase));
  iocm_mgr_model i_iocm_mgr_model (.i_clk(clk), .i_rsp(rsp), .o_req(od), .o_nmt_state(nmt));
  always #(CLK_NS / 2) clk = ~clk;
  // The storage side stalls every other cycle.
  always @(negedge clk) ee_rdy <= ~ee_rdy;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (emcy.vld === 1'b1)
    begin
      em_n <= em_n + 1;
      em_last <= {emcy.code, emcy.txt};
    end
    if (erase === 1'b1)
      er_n <= er_n + 1;
    if (aout.vld === 1'b1)
    begin
      an_n <= an_n + 1;
      av <= {aout.tx, aout.val};
    end
    if (ee.vld === 1'b1 && ee_rdy === 1'b1)
    begin
      chk({ee.addr, ee.d}, {12'(ee_n), fb[ee_n % 16]});
      ee_n <= ee_n + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic load(input logic [15:0] ix, input logic [7:0] sb, input logic [15:0] d);
    @(negedge clk);
    ld = '{vld: 1'b1, ix: ix, sub: sb, d: d};
    @(negedge clk);
    ld.vld = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [15:0] pick(input logic [15:0] ix, input logic [7:0] sb);
    if (ix == IX_PORT)
      return {7'h0, port[3'(sb - 8'h01)]};
    if (ix == IX_RMT)
      return (sb == 8'h01) ? {15'h0, fast} : {14'h0, rx_rep};
    return (sb == 8'h01) ? {14'h0, in_conv} : {14'h0, out_conv};
  endfunction
  task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
    input logic [31:0] wd, input logic e_er, input logic [7:0] e_rd, input int e_lat);
    i_iocm_mgr_model.xfer(w, ix, sb, wd, 1'b0, er, rd, lat);
    chk(er, e_er);
    if (!w && !e_er)
      chk(rd[7:0], e_rd);
    if (e_lat > 0)
      chk(lat, e_lat);
  endtask
  // Builds a file whose byte sum equals crr, then unlocks and sends it.
  task automatic dl(input int n, input logic [7:0] crr);
    logic [7:0] s;
    s = 8'h00;
    ee_n = 0;
    for (int i = 0; i < n; i++)
    begin
      fb[i] = (i < n - 1) ? 8'h11 + 8'(i % 6) : crr - s;
      s += fb[i];
    end
    i_iocm_mgr_model.xfer(1'b1, IX_DL, 8'h01, KEY_INIT, 1'b0, er, rd, lat);
    for (int i = 0; i < n; i++)
      i_iocm_mgr_model.xfer(1'b1, IX_DL, 8'h02, {24'h0, fb[i]}, i == n - 1, er, rd, lat);
  endtask
  task automatic wt(input int tgt, input logic [55:0] e);
    for (int k = 0; k < 2000 && em_n < tgt; k++)
      @(negedge clk);
    chk({8'(em_n), em_last}, {8'(tgt), e});
  endtask
  task automatic meas(input logic hb, input logic [15:0] ms, input int lim, input int e);
    int k;
    load(IX_HW, hb ? 8'h08 : 8'h04, ms);
    @(negedge clk);
    fatal = ~hb;
    boot = hb;
    @(negedge clk);
    fatal = 1'b0;
    boot = 1'b0;
    k = 1;
    while (k < lim && (hb ? extra_hb : self_rst) !== 1'b1)
    begin
      @(negedge clk);
      k++;
    end
    chk(k, e);
  endtask
  task automatic an(input logic [7:0] md, input logic [11:0] raw, input logic [16:0] e);
    int n0;
    n0 = an_n;
    load(IX_HW, 8'h05, {8'h00, md});
    @(negedge clk);
    ain = '{vld: 1'b1, ch: 3'h2, raw: raw};
    @(negedge clk);
    ain.vld = 1'b0;
    repeat (2) @(negedge clk);
    chk({8'(an_n - n0), av}, {8'h01, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({rsp.ack, emcy.vld, ee.vld, port}, '0);
    foreach (ROWS[i])
    begin
      load(ROWS[i].ix, ROWS[i].sb, {8'h00, ROWS[i].d});
      chk(pick(ROWS[i].ix, ROWS[i].sb), ROWS[i].e);
    end
    load(IX_HW, 8'h03, 16'h0000);
    acc(1'b0, IX_STAT, 8'h03, '0, 1'b0, 8'h00, 2);
    load(IX_PORT, 8'h07, 16'h0000);
    acc(1'b0, IX_STAT, 8'h03, '0, 1'b0, 8'h01, 0);
    load(IX_PORT, 8'h07, 16'h0051);
    load(IX_HW, 8'h07, 16'h0001);
    acc(1'b0, IX_STAT, 8'h01, '0, 1'b0, 8'h2A, CYC + 2);
    load(IX_HW, 8'h07, 16'h0000);
    acc(1'b1, IX_HW, 8'h01, 32'h0000_0001, 1'b1, 8'h00, 0);
    i_iocm_mgr_model.state(8'h05);
    acc(1'b1, IX_DL, 8'h01, KEY_INIT, 1'b1, 8'h00, 0);
    i_iocm_mgr_model.state(NMT_PREOP);
    acc(1'b1, IX_DL, 8'h02, 32'h0000_0011, 1'b1, 8'h00, 0);
    acc(1'b0, IX_DL, 8'h01, '0, 1'b1, 8'h00, 0);
    dl(8, 8'h00);
    wt(1, {EC_WAIT, TX_WAIT});
    wt(2, {EC_OVER, TX_OVER});
    chk(ee_n, 8);
    dl(8, 8'h01);
    wt(3, {EC_CSUM, TX_CSUM});
    chk(er_n, 1);
    dl(3, 8'h00);
    wt(4, {EC_BAD, TX_BAD});
    chk(er_n, 2);
    dl(8, 8'h00);
    wt(5, {EC_WAIT, TX_WAIT});
    repeat (4) @(negedge clk);
    ee_fail = 1'b1;
    @(negedge clk);
    ee_fail = 1'b0;
    wt(6, {EC_BAD, TX_PROG});
    chk(er_n, 3);
    i_iocm_mgr_model.xfer(1'b1, IX_DL, 8'h01, KEY_INIT, 1'b0, er, rd, lat);
    i_iocm_mgr_model.xfer(1'b1, IX_DL, 8'h01, KEY_BACK, 1'b0, er, rd, lat);
    repeat (3) @(negedge clk);
    chk(er_n, 4);
    meas(1'b0, 16'h0032, 9999, 100 * CYC + 1);
    meas(1'b0, 16'h00FA, 9999, 250 * CYC + 1);
    meas(1'b1, 16'h0001, 9999, 50 * CYC + 1);
    meas(1'b1, 16'h0000, 400, 400);
    load(IX_HW, 8'h06, 16'h0010);
    an(8'h01, 12'h00F, {1'b0, 16'h000F});
    an(8'h01, 12'h010, {1'b1, 16'h0010});
    an(8'h01, 12'h01F, {1'b0, 16'h001F});
    an(8'h00, 12'hABC, {1'b1, 16'hABC0});
    an(8'h02, 12'hABC, {1'b0, 16'hABCA});
    rst = 1'b1;
    @(negedge clk);
    chk({rsp.ack, emcy.vld, ee.vld, in_conv, port}, '0);
    rst = 1'b0;
    @(negedge clk);
    chk(port[0], 9'h002);
    tally_and_finish;
  end
  initial
  begin
    #200_000;
    err_total++;
    tally_and_finish;
  end
endmodule

// ==== verification/iocm_mgr_model.sv ====
`timescale 1ns/10ps
module iocm_mgr_model (
  input wire logic i_clk,
  input wire iocm_pkg::iocm_rsp_s i_rsp,
  output iocm_pkg::iocm_req_s o_req,
  output logic [7:0] o_nmt_state
);
  import iocm_pkg::*;
  initial
  begin
    o_req = '0;
    o_nmt_state = NMT_PREOP;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // The manager moves the node between network states on command.
  task automatic state(input logic [7:0] s);
    @(negedge i_clk);
    o_nmt_state = s;
  endtask
  // A request stands from a falling edge until its acknowledge has been seen.
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb,
    input logic [31:0] wd, input logic lst, output logic er, output logic [127:0] rd,
    output int lat);
    @(negedge i_clk);
    o_req = '{vld: 1'b1, wr: w, ix: ix, sub: sb, wd: wd, last: lst};
    lat = 0;
    do
    begin
      @(negedge i_clk);
      lat++;
    end
    while (i_rsp.ack !== 1'b1 && lat < 9999);
    er = i_rsp.err;
    rd = i_rsp.rd;
    // Released data must not keep showing the last value.
    o_req.vld = 1'b0;
    o_req.wd = ~wd;
  endtask
endmodule
